// *** hdl/timer16_waveform_mode_control.sv ***
// Waveform mode decode, counter, compare outputs and register slave.
// Assumes a classic Wishbone master on clk_i; timer clock is clk_i itself.
// Operation
// - Output action 10 or 11 hands the pin from port to waveform; 01 does so only where it toggles.
// - Pin driver is enabled only by the port direction bit.
// - Output action meaning depends on non-PWM, fast or dual-slope mode.
// - Non-PWM: 00 off, 01 toggle, 10 low, 11 high on match.
// - Fast PWM: 10 clears on match, sets at TOP; 11 the reverse.
// - Fast PWM code 01 toggles channel A only in modes 14, 15.
// - Fast PWM match equal to TOP is ignored; TOP action still done.
// - Dual-slope code 01 toggles channel A only in modes 8 to 11.
// - Dual-slope: 10 clears on up match, sets on down match; 11 reverse.
// - Mode is two low bits of control A and two bits of control B.
// - Mode picks normal, clear on match, or one of three PWM kinds.
// - Modes 8, 9: dual slope, TOP capture or A, reload and wrap at BOTTOM.
// - Modes 0, 4, 12 reload immediately, flag at MAX; 13 reserved.
// - Modes 1-3, 5-7 fixed TOPs; 10, 11, 14, 15 register TOP; reload at TOP.
// - Dual slope counts up to TOP, then straight back down without holding it.
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module timer16_waveform_mode_control
  import timer16_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic irq_o,
  output logic chan_a_wave_out_o,
  output logic chan_b_wave_out_o,
  output logic chan_a_pin_oe_n_o,
  output logic chan_b_pin_oe_n_o
);

  ////////////////////////////////////////////////////////////////////////////
  ctrl_a_type ctrl_q;
  logic [1:0] mode_high_q;
  logic [3:0] wave_mode_sel;
  logic [15:0] buf_q [2];
  logic [15:0] act_q [2];
  logic [15:0] capture_q;
  logic [15:0] cnt_q;
  logic down_q;
  logic [IRQ_W-1:0] stat_q;
  logic [IRQ_W-1:0] en_q;
  logic [IRQ_W-1:0] stat_d;
  logic [IRQ_W-1:0] evt;
  logic [1:0] dir_q;
  logic [1:0] port_data_q;
  logic [1:0] wave_q;
  logic [1:0] wave_d;
  logic [1:0] conn;
  logic [1:0] match;
  logic [1:0] pin_q;
  logic [1:0] oe_n_q;
  logic [1:0] action [2];
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] rd_data;
  logic irq_q;
  logic req;
  logic wr;
  logic at_top;
  logic reload;
  decode_type dec;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = old;
    if (s[0]) begin
      merge16[7:0] = d[7:0];
    end
    if (s[1]) begin
      merge16[15:8] = d[15:8];
    end
  endfunction : merge16

  ////////////////////////////////////////////////////////////////////////////
  assign wave_mode_sel = {mode_high_q, ctrl_q.wave_mode_low};
  assign action[0] = ctrl_q.chan_a_output_action;
  assign action[1] = ctrl_q.chan_b_output_action;

  always_comb begin
    dec.fam = FAM_NORMAL;
    dec.upd = UPD_NOW;
    dec.wrap = WRAP_MAX;
    dec.top = TOP_MAX;
    unique case (wave_mode_sel)
      MODE_NORMAL: begin
        dec.fam = FAM_NORMAL;
      end
      MODE_CTC_A, MODE_CTC_CAP: begin
        dec.fam = FAM_CTC;
      end
      MODE_RSVD: begin
        dec.fam = FAM_RESERVED;
      end
      MODE_FAST8, MODE_FAST9, MODE_FAST10, MODE_FAST_CAP, MODE_FAST_A: begin
        dec.fam = FAM_FAST;
        dec.upd = UPD_TOP;
        dec.wrap = WRAP_TOP;
      end
      MODE_PC8, MODE_PC9, MODE_PC10, MODE_PC_CAP, MODE_PC_A: begin
        dec.fam = FAM_PHASE;
        dec.upd = UPD_TOP;
        dec.wrap = WRAP_BOTTOM;
      end
      MODE_PFC_CAP, MODE_PFC_A: begin
        dec.fam = FAM_PHASE_FREQ;
        dec.upd = UPD_BOTTOM;
        dec.wrap = WRAP_BOTTOM;
      end
    endcase
    unique case (wave_mode_sel)
      MODE_PC8, MODE_FAST8: dec.top = TOP_8BIT;
      MODE_PC9, MODE_FAST9: dec.top = TOP_9BIT;
      MODE_PC10, MODE_FAST10: dec.top = TOP_10BIT;
      MODE_CTC_A, MODE_PFC_A, MODE_PC_A, MODE_FAST_A: dec.top = act_q[0];
      MODE_CTC_CAP, MODE_PFC_CAP, MODE_PC_CAP, MODE_FAST_CAP: dec.top = capture_q;
      MODE_NORMAL, MODE_RSVD: dec.top = TOP_MAX;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter; single slope wraps by ==, so a TOP set below the count runs to MAX
  assign at_top = (cnt_q == dec.top);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= BOTTOM;
      down_q <= 1'b0;
    end else if (dec.fam == FAM_PHASE || dec.fam == FAM_PHASE_FREQ) begin
      if (down_q) begin
        if (cnt_q == BOTTOM) begin
          down_q <= 1'b0;
          cnt_q <= cnt_q + ONE;
        end else begin
          cnt_q <= cnt_q - ONE;
        end
      end else if (at_top) begin
        down_q <= 1'b1;
        cnt_q <= cnt_q - ONE;
      end else begin
        cnt_q <= cnt_q + ONE;
      end
    end else begin
      down_q <= 1'b0;
      cnt_q <= at_top ? BOTTOM : cnt_q + ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    reload = 1'b0;
    unique case (dec.upd)
      UPD_NOW: reload = 1'b1;
      UPD_TOP: reload = at_top;
      UPD_BOTTOM: reload = (cnt_q == BOTTOM);
    endcase
  end

  always_comb begin
    evt = '0;
    unique case (dec.wrap)
      WRAP_MAX: evt[IRQ_WRAP] = (cnt_q == TOP_MAX);
      WRAP_TOP: evt[IRQ_WRAP] = at_top;
      WRAP_BOTTOM: evt[IRQ_WRAP] = (cnt_q == BOTTOM) && down_q;
    endcase
    evt[IRQ_MATCH_A] = match[0];
    evt[IRQ_MATCH_B] = match[1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel compare buffer and waveform
  for (genvar i = 0; i < 2; i++) begin : g_chan
    logic tog_ok;
    logic [7:0] buf_adr;
    assign buf_adr = (i == 0) ? ADR_MATCH_A : ADR_MATCH_B;
    assign match[i] = (cnt_q == act_q[i]);

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        buf_q[i] <= BOTTOM;
        act_q[i] <= BOTTOM;
      end else begin
        if (wr && adr_i == buf_adr) begin
          buf_q[i] <= merge16(buf_q[i], dat_i, sel_i);
        end
        if (reload) begin
          act_q[i] <= buf_q[i];
        end
      end
    end

    always_comb begin
      tog_ok = 1'b0;
      wave_d[i] = wave_q[i];
      unique case (dec.fam)
        FAM_NORMAL, FAM_CTC, FAM_RESERVED: begin
          tog_ok = 1'b1;
          if (match[i]) begin
            unique case (action[i])
              ACT_OFF: wave_d[i] = wave_q[i];
              ACT_TOGGLE: wave_d[i] = ~wave_q[i];
              ACT_CLEAR: wave_d[i] = 1'b0;
              ACT_SET: wave_d[i] = 1'b1;
            endcase
          end
        end
        FAM_FAST: begin
          tog_ok = (i == 0) && wave_mode_sel[3:1] == MODE_FAST_CAP[3:1];
          if (action[i] == ACT_TOGGLE) begin
            wave_d[i] = (tog_ok && match[i]) ? ~wave_q[i] : wave_q[i];
          end else if (action[i][1] && at_top) begin
            wave_d[i] = ~action[i][0];
          end else if (action[i][1] && match[i]) begin
            wave_d[i] = action[i][0];
          end
        end
        FAM_PHASE, FAM_PHASE_FREQ: begin
          tog_ok = (i == 0) && wave_mode_sel[3:2] == MODE_PFC_CAP[3:2];
          if (action[i] == ACT_TOGGLE) begin
            wave_d[i] = (tog_ok && match[i]) ? ~wave_q[i] : wave_q[i];
          end else if (action[i][1] && match[i]) begin
            wave_d[i] = action[i][0] ^ down_q;
          end
        end
      endcase
      conn[i] = action[i][1] | (action[i][0] & tog_ok);
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        wave_q[i] <= 1'b0;
        pin_q[i] <= 1'b0;
        oe_n_q[i] <= 1'b1;
      end else begin
        wave_q[i] <= wave_d[i];
        pin_q[i] <= conn[i] ? wave_d[i] : port_data_q[i];
        oe_n_q[i] <= ~dir_q[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave; one wait state, unmapped reads return zero
  assign req = cyc_i && stb_i && !ack_q;
  assign wr = req && we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RESET;
      mode_high_q <= 2'h0;
      capture_q <= BOTTOM;
      en_q <= '0;
      dir_q <= 2'h0;
      port_data_q <= 2'h0;
    end else if (wr && sel_i[0]) begin
      unique case (adr_i)
        ADR_CTRL_A: begin
          ctrl_q <= dat_i[7:0];
          ctrl_q.unused <= 2'h0;
        end
        ADR_CTRL_B: mode_high_q <= dat_i[MODE_HIGH_POS+:2];
        ADR_IRQ_EN: en_q <= dat_i[IRQ_W-1:0];
        ADR_PORT: begin
          dir_q <= dat_i[1:0];
          port_data_q <= dat_i[PORT_DATA_POS+:2];
        end
        default: ;
      endcase
    end
    if (!rst_i && wr && adr_i == ADR_CAPTURE) begin
      capture_q <= merge16(capture_q, dat_i, sel_i);
    end
  end

  always_comb begin
    rd_data = 32'h00000000;
    unique case (adr_i)
      ADR_CTRL_A: rd_data[7:0] = ctrl_q;
      ADR_CTRL_B: rd_data[MODE_HIGH_POS+:2] = mode_high_q;
      ADR_MATCH_A: rd_data[15:0] = buf_q[0];
      ADR_MATCH_B: rd_data[15:0] = buf_q[1];
      ADR_CAPTURE: rd_data[15:0] = capture_q;
      ADR_COUNT: rd_data[15:0] = cnt_q;
      ADR_IRQ_STAT: rd_data[IRQ_W-1:0] = stat_q;
      ADR_IRQ_EN: rd_data[IRQ_W-1:0] = en_q;
      ADR_PORT: rd_data[3:0] = {port_data_q, dir_q};
      default: rd_data = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= req;
      dat_q <= (req && !we_i) ? rd_data : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status: a new event beats a clear in the same cycle
  always_comb begin
    stat_d = stat_q;
    if (wr && sel_i[0] && adr_i == ADR_IRQ_CLR) begin
      stat_d = stat_q & ~dat_i[IRQ_W-1:0];
    end
    stat_d = stat_d | evt;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_q <= |(stat_d & en_q);
    end
  end

  assign dat_o = dat_q;
  assign ack_o = ack_q;
  assign irq_o = irq_q;
  assign chan_a_wave_out_o = pin_q[0];
  assign chan_b_wave_out_o = pin_q[1];
  assign chan_a_pin_oe_n_o = oe_n_q[0];
  assign chan_b_pin_oe_n_o = oe_n_q[1];

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_port_owns;
    action[0] == ACT_OFF |=> chan_a_wave_out_o == $past(port_data_q[0]);
  endproperty
  a_port_owns: assert property (p_port_owns) else $error("port lost pin");

  property p_oe_dir;
    !dir_q[1] |=> chan_b_pin_oe_n_o;
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("driver on as input");

  property p_nonpwm_set;
    (dec.fam == FAM_CTC && action[0] == ACT_SET && match[0]) |=> chan_a_wave_out_o;
  endproperty
  a_nonpwm_set: assert property (p_nonpwm_set) else $error("set on match failed");

  property p_fast_top;
    (dec.fam == FAM_FAST && action[1] == ACT_CLEAR && at_top) |=> chan_b_wave_out_o;
  endproperty
  a_fast_top: assert property (p_fast_top) else $error("no set at TOP");

  property p_fast_tog_off;
    (dec.fam == FAM_FAST && action[0] == ACT_TOGGLE && !wave_mode_sel[3])
      |=> chan_a_wave_out_o == $past(port_data_q[0]);
  endproperty
  a_fast_tog_off: assert property (p_fast_tog_off) else $error("toggle leaked");

  property p_fast_ign;
    (dec.fam == FAM_FAST && action[0] == ACT_SET && at_top && match[0])
      |=> !chan_a_wave_out_o;
  endproperty
  a_fast_ign: assert property (p_fast_ign) else $error("TOP match not ignored");

  property p_dual_b_tog;
    (dec.fam == FAM_PHASE && action[1] == ACT_TOGGLE)
      |=> chan_b_wave_out_o == $past(port_data_q[1]);
  endproperty
  a_dual_b_tog: assert property (p_dual_b_tog) else $error("B toggle leaked");

  property p_dual_up;
    (dec.fam == FAM_PHASE_FREQ && action[0] == ACT_CLEAR && match[0] && !down_q)
      |=> !chan_a_wave_out_o;
  endproperty
  a_dual_up: assert property (p_dual_up) else $error("up match not cleared");

  property p_pfc_wrap;
    (dec.fam == FAM_PHASE_FREQ && cnt_q == BOTTOM && down_q) |=> stat_q[IRQ_WRAP];
  endproperty
  a_pfc_wrap: assert property (p_pfc_wrap) else $error("wrap flag missed");

  property p_ctc_clr;
    (wave_mode_sel == MODE_CTC_A && at_top) |=> cnt_q == BOTTOM;
  endproperty
  a_ctc_clr: assert property (p_ctc_clr) else $error("no clear on match");

  property p_top_hold;
    (dec.fam == FAM_PHASE && !down_q && at_top && cnt_q > ONE)
      |=> down_q && cnt_q == $past(cnt_q) - ONE;
  endproperty
  a_top_hold: assert property (p_top_hold) else $error("bad turn at TOP");

  property p_rsvd_zero;
    (req && !we_i && adr_i == ADR_CTRL_A) |=> ack_o && dat_o[3:2] == 2'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");

  c_fast_a: cover property (dec.fam == FAM_FAST && conn[0] ##1 chan_a_wave_out_o);
  c_dual_turn: cover property (dec.fam == FAM_PHASE_FREQ && at_top ##1 down_q);
  c_irq: cover property (!irq_o ##1 irq_o);

endmodule : timer16_waveform_mode_control

// *** shared/timer16_pkg.sv ***
// Constants, types and register map for the 16-bit timer waveform block.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package timer16_pkg;
  localparam logic [7:0] ADR_CTRL_A = 8'h00;
  localparam logic [7:0] ADR_CTRL_B = 8'h04;
  localparam logic [7:0] ADR_MATCH_A = 8'h08;
  localparam logic [7:0] ADR_MATCH_B = 8'h0C;
  localparam logic [7:0] ADR_CAPTURE = 8'h10;
  localparam logic [7:0] ADR_COUNT = 8'h14;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADR_IRQ_CLR = 8'h1C;
  localparam logic [7:0] ADR_IRQ_EN = 8'h20;
  localparam logic [7:0] ADR_PORT = 8'h24;
  localparam int MODE_HIGH_POS = 3;
  localparam int PORT_DATA_POS = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_PC8 = 4'h1;
  localparam logic [3:0] MODE_PC9 = 4'h2;
  localparam logic [3:0] MODE_PC10 = 4'h3;
  localparam logic [3:0] MODE_CTC_A = 4'h4;
  localparam logic [3:0] MODE_FAST8 = 4'h5;
  localparam logic [3:0] MODE_FAST9 = 4'h6;
  localparam logic [3:0] MODE_FAST10 = 4'h7;
  localparam logic [3:0] MODE_PFC_CAP = 4'h8;
  localparam logic [3:0] MODE_PFC_A = 4'h9;
  localparam logic [3:0] MODE_PC_CAP = 4'hA;
  localparam logic [3:0] MODE_PC_A = 4'hB;
  localparam logic [3:0] MODE_CTC_CAP = 4'hC;
  localparam logic [3:0] MODE_RSVD = 4'hD;
  localparam logic [3:0] MODE_FAST_CAP = 4'hE;
  localparam logic [3:0] MODE_FAST_A = 4'hF;
  localparam logic [15:0] TOP_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [15:0] ONE = 16'h0001;
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  localparam int IRQ_WRAP = 0;
  localparam int IRQ_MATCH_A = 1;
  localparam int IRQ_MATCH_B = 2;
  localparam int IRQ_W = 3;
  typedef enum {FAM_NORMAL, FAM_CTC, FAM_FAST, FAM_PHASE, FAM_PHASE_FREQ, FAM_RESERVED}
    family_type;
  typedef enum {UPD_NOW, UPD_TOP, UPD_BOTTOM} update_type;
  typedef enum {WRAP_MAX, WRAP_TOP, WRAP_BOTTOM} wrap_type;
  typedef struct packed {
    logic [1:0] chan_a_output_action;
    logic [1:0] chan_b_output_action;
    logic [1:0] unused;
    logic [1:0] wave_mode_low;
  } ctrl_a_type;
  typedef struct packed {
    family_type fam;
    update_type upd;
    wrap_type wrap;
    logic [15:0] top;
  } decode_type;
endpackage : timer16_pkg

// *** tb/port_pin_model.sv ***
// Port pin model: one pad of the timer's compare channel.
// Assumes an active-low driver enable and a weak pull-up on the pad.
`timescale 1ns/1ps
module port_pin_model (
  input wire logic wave_i,
  input wire logic oe_n_i,
  output logic pin_o
);
  // Released pad settles at the pull-up level, never at the last value
  assign pin_o = oe_n_i ? 1'b1 : wave_i;
endmodule : port_pin_model

// *** tb/tb.sv ***
// Testbench: register access over classic Wishbone, pin duty measurement.
// Assumes the timer block on a 40 MHz clock and two pull-up port pads.
`timescale 1ns/1ps
module tb
  import timer16_pkg::*;
;
  typedef struct packed {
    logic [3:0] mode;
    logic [1:0] act_a;
    logic [1:0] act_b;
    logic a_first;
    logic [15:0] cap;
    logic [15:0] ma;
    logic [15:0] mb;
    logic [1:0] pd;
    logic [9:0] ea;
    logic [9:0] eb;
  } row_type;
  // Order keeps the counter below every new TOP, avoiding a run to MAX
  localparam row_type ROWS [12] = '{
    '{4'h9, 2'h1, 2'h1, 1'b0, 16'h0080, 16'h0080, 16'h0020, 2'h2, 10'h100, 10'h200},
    '{4'h8, 2'h2, 2'h3, 1'b0, 16'h0080, 16'h0020, 16'h0020, 2'h0, 10'h080, 10'h180},
    '{4'hA, 2'h3, 2'h1, 1'b0, 16'h0080, 16'h0020, 16'h0020, 2'h2, 10'h180, 10'h200},
    '{4'h5, 2'h2, 2'h3, 1'b0, 16'h0080, 16'h0040, 16'h00FF, 2'h0, 10'h082, 10'h000},
    '{4'h5, 2'h3, 2'h2, 1'b0, 16'h0080, 16'h0040, 16'h00FF, 2'h0, 10'h17E, 10'h200},
    '{4'h5, 2'h1, 2'h1, 1'b0, 16'h0080, 16'h0040, 16'h00FF, 2'h2, 10'h000, 10'h200},
    '{4'hE, 2'h1, 2'h2, 1'b1, 16'h00FF, 16'h00FF, 16'h0080, 2'h0, 10'h100, 10'h102},
    '{4'hF, 2'h1, 2'h1, 1'b0, 16'h00FF, 16'h00FF, 16'h0080, 2'h2, 10'h100, 10'h200},
    '{4'hC, 2'h1, 2'h3, 1'b0, 16'h00FF, 16'h0040, 16'h0010, 2'h0, 10'h100, 10'h200},
    '{4'h4, 2'h3, 2'h1, 1'b0, 16'h00FF, 16'h00FF, 16'h0010, 2'h0, 10'h200, 10'h100},
    '{4'h4, 2'h2, 2'h0, 1'b0, 16'h00FF, 16'h00FF, 16'h0010, 2'h2, 10'h000, 10'h200},
    '{4'h4, 2'h0, 2'h2, 1'b0, 16'h00FF, 16'h00FF, 16'h0010, 2'h1, 10'h200, 10'h000}
  };
  logic clk_i;
  logic rst_i;
  logic cyc;
  logic stb;
  logic we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat;
  logic [31:0] dat_o;
  logic ack_o;
  logic irq_o;
  logic wave_a;
  logic wave_b;
  logic oe_n_a;
  logic oe_n_b;
  logic pin_a;
  logic pin_b;
  logic [31:0] q;
  logic [9:0] ha;
  logic [9:0] hb;
  int errors;
  int total_checks;
  ////////////////////////////////////////
  timer16_waveform_mode_control DUT (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc),
    .stb_i(stb),
    .we_i(we),
    .adr_i(adr),
    .sel_i(sel),
    .dat_i(dat),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .irq_o(irq_o),
    .chan_a_wave_out_o(wave_a),
    .chan_b_wave_out_o(wave_b),
    .chan_a_pin_oe_n_o(oe_n_a),
    .chan_b_pin_oe_n_o(oe_n_b)
  );
  port_pin_model pad_a (.wave_i(wave_a), .oe_n_i(oe_n_a), .pin_o(pin_a));
  port_pin_model pad_b (.wave_i(wave_b), .oe_n_i(oe_n_b), .pin_o(pin_b));
  initial clk_i = 1'b0;
  always #12.5 clk_i = ~clk_i;
  ////////////////////////////////////////
  task give_verdict;
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  // Classic single cycle; no answer latency assumed, bounded wait only
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      errors++;
      give_verdict();
    end
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    wb(1'b0, a, 32'h0, r);
  endtask : rd
  // Window of 512 cycles spans whole periods of every row
  task automatic measure(output logic [9:0] ca, output logic [9:0] cb);
    int na;
    int nb;
    na = 0;
    nb = 0;
    repeat (512) begin
      @(posedge clk_i);
      if (pin_a === 1'b1) na++;
      if (pin_b === 1'b1) nb++;
    end
    ca = na[9:0];
    cb = nb[9:0];
  endtask : measure
  ////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0;
    errors = 0;
    total_checks = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({30'h0, oe_n_b, oe_n_a}, 32'h3);
    chk({31'h0, irq_o}, 32'h0);
    rd(ADR_CTRL_A, q);
    chk(q, 32'h0);
    wr(ADR_PORT, 32'h0000000D);
    repeat (2) @(posedge clk_i);
    chk({30'h0, oe_n_b, oe_n_a}, 32'h2);
    chk({30'h0, pin_b, pin_a}, 32'h3);
    wr(ADR_PORT, 32'h00000001);
    repeat (2) @(posedge clk_i);
    chk({31'h0, pin_a}, 32'h0);
    for (int i = 0; i < 12; i++) begin
      wr(ADR_CAPTURE, {16'h0, ROWS[i].cap});
      wr(ADR_MATCH_A, {16'h0, ROWS[i].ma});
      wr(ADR_MATCH_B, {16'h0, ROWS[i].mb});
      wr(ADR_PORT, {28'h0, ROWS[i].pd, 2'h3});
      if (ROWS[i].a_first) wr(ADR_CTRL_A, {24'h0, ROWS[i].act_a, ROWS[i].act_b,
          2'h0, ROWS[i].mode[1:0]});
      wr(ADR_CTRL_B, {27'h0, ROWS[i].mode[3:2], 3'h0});
      if (!ROWS[i].a_first) wr(ADR_CTRL_A, {24'h0, ROWS[i].act_a, ROWS[i].act_b,
          2'h0, ROWS[i].mode[1:0]});
      repeat (600) @(posedge clk_i);
      measure(ha, hb);
      chk({22'h0, ha}, {22'h0, ROWS[i].ea});
      chk({22'h0, hb}, {22'h0, ROWS[i].eb});
    end
    // Match B beyond TOP never fires; CLEAR_ON_MATCH_MODE never reaches MAX
    wr(ADR_MATCH_B, 32'h000001FF);
    repeat (20) @(posedge clk_i);
    wr(ADR_IRQ_CLR, 32'h00000007);
    rd(ADR_IRQ_STAT, q);
    chk(q & 32'h5, 32'h0);
    repeat (300) @(posedge clk_i);
    rd(ADR_IRQ_STAT, q);
    chk(q & 32'h7, 32'h2);
    wr(ADR_IRQ_EN, 32'h00000002);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    wr(ADR_IRQ_EN, 32'h00000004);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    rd(ADR_IRQ_CLR, q);
    chk(q, 32'h0);
    rd(8'h30, q);
    chk(q, 32'h0);
    rd(ADR_COUNT, q);
    chk({31'h0, q < 32'h100}, 32'h1);
    wr(ADR_CTRL_B, 32'h00000008);
    wr(ADR_CTRL_A, 32'h00000001);
    wr(ADR_IRQ_CLR, 32'h00000007);
    repeat (300) @(posedge clk_i);
    rd(ADR_IRQ_STAT, q);
    chk(q & 32'h1, 32'h1);
    wr(ADR_CTRL_A, 32'h000000FF);
    rd(ADR_CTRL_A, q);
    chk(q, 32'h000000F3);
    give_verdict();
  end
endmodule : tb
